/* File: tcm_top.sv */
// tcm_top: compare-output timer stage with counter, buffers and register slave
module tcm_top
  import tcm_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic        timer_tick_enable,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        port_data_a,
  input  wire logic        port_data_b,
  input  wire logic        port_data_c,
  input  wire logic        port_dir_a,
  input  wire logic        port_dir_b,
  input  wire logic        port_dir_c,
  output logic             chan_a_compare_pin,
  output logic             chan_b_compare_pin,
  output logic             chan_c_compare_pin,
  output logic             chan_a_compare_pin_oe,
  output logic             chan_b_compare_pin_oe,
  output logic             chan_c_compare_pin_oe
);
  // ==========================================================
  // state
  logic [7:0]  ctrl_a_r;
  logic [1:0]  wgm_hi_r;
  logic [15:0] cmp_buf_r [0:2];
  logic [15:0] cmp_act_r [0:2];
  logic [15:0] cap_top_r;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  tcm_dir_t    dir_r;
  tcm_dir_t    dir_nxt;
  logic        wait_r;
  logic [31:0] rdata_r;
  logic [2:0]  pin_r;
  logic [2:0]  oe_r;

  // ==========================================================
  // decode helpers
  logic        tick;
  logic [3:0]  wgm;
  tcm_cls_t    cls;
  tcm_top_t    top_sel;
  tcm_upd_t    upd;
  logic [15:0] top_val;
  logic        at_top;
  logic        at_bot;
  logic [1:0]  com [0:2];
  logic [2:0]  match;
  logic [2:0]  oc;
  logic [2:0]  linked;
  logic [2:0]  port_data;
  logic [2:0]  port_dir;
  logic [4:0]  addr_w;
  logic        wr_go;
  logic        cnt_wr;
  logic [31:0] rd_mux;

  assign tick      = clk_en && timer_tick_enable;
  assign wgm       = {wgm_hi_r, ctrl_a_r[WGM_LO_LSB +: 2]};
  assign addr_w    = {avs_address[4:2], 2'b00};
  assign wr_go     = clk_en && avs_write && !wait_r;
  assign cnt_wr    = wr_go && (addr_w == OFS_COUNT);
  assign at_top    = (cnt_r == top_val);
  assign at_bot    = (cnt_r == WORD_RST);
  assign port_data = {port_data_c, port_data_b, port_data_a};
  assign port_dir  = {port_dir_c, port_dir_b, port_dir_a};

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be);
    logic [15:0] res;
    res = old;
    if (be[0]) begin
      res[7:0] = wd[7:0];
    end
    if (be[1]) begin
      res[15:8] = wd[15:8];
    end
    return res;
  endfunction : merge16

  tcm_mode_dec u_dec (
    .wgm     (wgm),
    .cls     (cls),
    .top_sel (top_sel),
    .upd     (upd)
  );

  always_comb begin
    case (top_sel)
      TOP_00FF: top_val = TOP_8BIT;
      TOP_01FF: top_val = TOP_9BIT;
      TOP_03FF: top_val = TOP_10BIT;
      TOP_CAP:  top_val = cap_top_r;
      TOP_CMPA: top_val = cmp_act_r[0];
      default:  top_val = TOP_MAX;
    endcase
  end

  // ==========================================================
  // register bus slave: one wait cycle per access
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_r <= 1'b1;
    end else if (clk_en) begin
      wait_r <= !((avs_read || avs_write) && wait_r);
    end
  end

  always_comb begin
    case (addr_w)
      OFS_CTRL_A:  rd_mux = {24'h000000, ctrl_a_r};
      OFS_CTRL_B:  rd_mux = {27'h0000000, wgm_hi_r, 3'h0};
      OFS_CMP_A:   rd_mux = {16'h0000, cmp_buf_r[0]};
      OFS_CMP_B:   rd_mux = {16'h0000, cmp_buf_r[1]};
      OFS_CMP_C:   rd_mux = {16'h0000, cmp_buf_r[2]};
      OFS_CAP_TOP: rd_mux = {16'h0000, cap_top_r};
      OFS_COUNT:   rd_mux = {16'h0000, cnt_r};
      OFS_STATUS:  rd_mux = {25'h0000000, (dir_r == DIR_DOWN), linked, oc};
      default:     rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 32'h00000000;
    end else if (clk_en && avs_read && wait_r) begin
      rdata_r <= rd_mux;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_a_r <= CTRL_RST;
      wgm_hi_r <= 2'h0;
    end else if (wr_go && avs_byteenable[0]) begin
      if (addr_w == OFS_CTRL_A) begin
        ctrl_a_r <= avs_writedata[7:0];
      end
      if (addr_w == OFS_CTRL_B) begin
        wgm_hi_r <= avs_writedata[WGM_HI_LSB +: 2];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cap_top_r <= WORD_RST;
      for (int i = 0; i < 3; i++) begin
        cmp_buf_r[i] <= WORD_RST;
      end
    end else if (wr_go) begin
      if (addr_w == OFS_CAP_TOP) begin
        cap_top_r <= merge16(cap_top_r, avs_writedata, avs_byteenable);
      end
      for (int i = 0; i < 3; i++) begin
        if (addr_w == OFS_CMP_A + 5'(4 * i)) begin
          cmp_buf_r[i] <= merge16(cmp_buf_r[i], avs_writedata, avs_byteenable);
        end
      end
    end
  end

  // ==========================================================
  // compare buffer to active value
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 3; i++) begin
        cmp_act_r[i] <= WORD_RST;
      end
    end else if (clk_en) begin
      for (int i = 0; i < 3; i++) begin
        case (upd)
          UPD_TOP: if (tick && at_top) begin
            cmp_act_r[i] <= cmp_buf_r[i];
          end
          UPD_BOT: if (tick && at_bot) begin
            cmp_act_r[i] <= cmp_buf_r[i];
          end
          default: cmp_act_r[i] <= cmp_buf_r[i];
        endcase
      end
    end
  end

  // ==========================================================
  // counter sequence
  always_comb begin
    cnt_nxt = cnt_r;
    dir_nxt = dir_r;
    case (cls)
      CLS_NORMAL, CLS_CTC, CLS_FAST: begin
        cnt_nxt = at_top ? WORD_RST : cnt_r + 16'h0001;
        dir_nxt = DIR_UP;
      end
      CLS_PC, CLS_PFC: begin
        case (dir_r)
          DIR_UP: begin
            cnt_nxt = at_top ? cnt_r - 16'h0001 : cnt_r + 16'h0001;
            dir_nxt = at_top ? DIR_DOWN : DIR_UP;
          end
          DIR_DOWN: begin
            cnt_nxt = at_bot ? cnt_r + 16'h0001 : cnt_r - 16'h0001;
            dir_nxt = at_bot ? DIR_UP : DIR_DOWN;
          end
          default: dir_nxt = DIR_UP;
        endcase
      end
      default: cnt_nxt = cnt_r;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= WORD_RST;
      dir_r <= DIR_UP;
    end else if (cnt_wr) begin
      cnt_r <= merge16(cnt_r, avs_writedata, avs_byteenable);
    end else if (tick) begin
      cnt_r <= cnt_nxt;
      dir_r <= dir_nxt;
    end
  end

  // ==========================================================
  // channels
  for (genvar g = 0; g < 3; g++) begin : g_chan
    assign com[g]   = ctrl_a_r[MODE_A_LSB - 2 * g +: 2];
    assign match[g] = (cnt_r == cmp_act_r[g]);
    tcm_out_chan #(
      .IS_CHAN_A (g == 0)
    ) u_chan (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .tick    (tick),
      .wgm     (wgm),
      .cls     (cls),
      .com     (com[g]),
      .match   (match[g]),
      .at_top  (at_top),
      .cnt_up  (dir_r == DIR_UP),
      .oc_r    (oc[g]),
      .linked  (linked[g])
    );
  end

  // ==========================================================
  // pin drive
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_r <= 3'h0;
      oe_r  <= 3'h0;
    end else if (clk_en) begin
      for (int i = 0; i < 3; i++) begin
        pin_r[i] <= linked[i] ? oc[i] : port_data[i];
        oe_r[i]  <= port_dir[i];
      end
    end
  end

  assign avs_readdata          = rdata_r;
  assign avs_waitrequest       = wait_r;
  assign chan_a_compare_pin    = pin_r[0];
  assign chan_b_compare_pin    = pin_r[1];
  assign chan_c_compare_pin    = pin_r[2];
  assign chan_a_compare_pin_oe = oe_r[0];
  assign chan_b_compare_pin_oe = oe_r[1];
  assign chan_c_compare_pin_oe = oe_r[2];

  // ==========================================================
  // assertions
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  a_bus_one_wait: assert property (clk_en && (avs_read || avs_write) && avs_waitrequest
                                   |=> !avs_waitrequest)
    else $error("waitrequest not released after one cycle");
  a_freeze_no_tick: assert property (!timer_tick_enable && !cnt_wr |=> $stable(cnt_r) && $stable(oc))
    else $error("counter or output moved without a tick");
  a_pfc_load_bot: assert property (tick && upd == UPD_BOT && at_bot
                                   |=> cmp_act_r[1] == $past(cmp_buf_r[1]))
    else $error("compare buffer not loaded at bottom");
  a_pfc_hold_top: assert property (tick && upd == UPD_BOT && at_top && !at_bot
                                   |=> $stable(cmp_act_r[1]))
    else $error("compare value loaded at top in bottom-update mode");
  a_ctrl_a_write: assert property (wr_go && addr_w == OFS_CTRL_A && avs_byteenable[0]
                                   |=> ctrl_a_r == $past(avs_writedata[7:0]))
    else $error("control A write lost");
  a_pin_takeover: assert property (clk_en && linked[2] |=> chan_c_compare_pin == $past(oc[2]))
    else $error("compare output not on pin");
  a_pin_oe_dir: assert property (clk_en |=> chan_b_compare_pin_oe == $past(port_dir_b))
    else $error("pin enable not from direction bit");
  a_pin_port_off: assert property (clk_en && com[0] == COM_OFF
                                   |=> chan_a_compare_pin == $past(port_data_a))
    else $error("pin not under port control");
  a_nonpwm_toggle: assert property (tick && cls == CLS_NORMAL && com[0] == COM_TGL && match[0]
                                    |=> oc[0] != $past(oc[0]))
    else $error("non-PWM toggle missing");
  a_fast_b_off: assert property (cls == CLS_FAST && com[1] == COM_TGL |-> !linked[1])
    else $error("channel B toggle connected in fast PWM");
  a_fast_top_set: assert property (tick && cls == CLS_FAST && com[1][1] && at_top
                                   |=> oc[1] != $past(com[1][0]))
    else $error("fast PWM set at TOP missing");
  a_fast_eq_top: assert property (tick && cls == CLS_FAST && com[2][1] && at_top && match[2]
                                  |=> oc[2] != $past(com[2][0]))
    else $error("match at TOP not ignored");
  a_dual_c_off: assert property (cls == CLS_PC && com[2] == COM_TGL |-> !linked[2])
    else $error("channel C toggle connected in dual slope");
  a_dual_up_clr: assert property (tick && cls == CLS_PC && com[0] == COM_CLR && match[0]
                                  && dir_r == DIR_UP |=> !oc[0])
    else $error("up-count clear missing");
  a_dual_down_clr: assert property (tick && cls == CLS_PFC && com[1] == COM_SET && match[1]
                                    && dir_r == DIR_DOWN |=> !oc[1])
    else $error("down-count clear missing");
  a_half_duty: assert property (tick && wgm == WGM_DUAL_HI && com[0] == COM_TGL && at_top
                                |=> oc[0] != $past(oc[0]))
    else $error("channel A toggle at TOP missing");

  c_fast_top: cover property (tick && cls == CLS_FAST && at_top && com[0] == COM_CLR);
  c_pfc_load: cover property (tick && upd == UPD_BOT && at_bot);
  c_bus_write: cover property (wr_go);
  c_bus_read: cover property (clk_en && avs_read && !wait_r);
endmodule : tcm_top

/* File: tcm_pkg.sv */
// tcm_pkg: register map, field layout and encodings of the compare-output timer stage
// How it works
// - all logic runs on ref_clk; the timer tick only qualifies it as an enable
// - phase-and-frequency-correct mode loads compare values from buffers at BOTTOM
// - mode fields: channel A bits 7:6, channel B bits 5:4, channel C bits 3:2
// - a nonzero mode field hands the pin from the port to the compare output, except value 1 where the toggle is not allowed
// - the pin driver is enabled only by the port direction bit
// - mode value zero leaves the pin under normal port control
// - non-PWM compare match: 1 toggles, 2 clears, 3 sets the output
// - fast PWM value 1 toggles channel A only, only for waveform 14 or 15
// - fast PWM: 2 clears on match and sets at TOP; 3 the reverse
// - fast PWM, compare equal TOP, upper bit set: match ignored, TOP action kept
// - dual-slope value 1 toggles channel A only, only for waveforms 8 to 11
// - dual-slope value 2: clear on up-count match, set on down-count match
// - dual-slope value 3: set on up-count match, clear on down-count match
// - waveform bits 1:0 join two upper bits held in control register B
// - waveform decode yields mode class and TOP source; value 13 is reserved
// - dual-slope, TOP from channel A compare, value 1: channel A toggles at 50%
package tcm_pkg;
  // ==========================================================
  // register map (byte addresses, one word each)
  localparam logic [4:0]  OFS_CTRL_A    = 5'h00;
  localparam logic [4:0]  OFS_CTRL_B    = 5'h04;
  localparam logic [4:0]  OFS_CMP_A     = 5'h08;
  localparam logic [4:0]  OFS_CMP_B     = 5'h0C;
  localparam logic [4:0]  OFS_CMP_C     = 5'h10;
  localparam logic [4:0]  OFS_CAP_TOP   = 5'h14;
  localparam logic [4:0]  OFS_COUNT     = 5'h18;
  localparam logic [4:0]  OFS_STATUS    = 5'h1C;
  // ==========================================================
  // field positions and reset values
  localparam int          MODE_A_LSB    = 6;
  localparam int          WGM_LO_LSB    = 0;
  localparam int          WGM_HI_LSB    = 3;
  localparam logic [7:0]  CTRL_RST      = 8'h00;
  localparam logic [15:0] WORD_RST      = 16'h0000;
  // ==========================================================
  // fixed TOP values and waveform numbers
  localparam logic [15:0] TOP_MAX       = 16'hFFFF;
  localparam logic [15:0] TOP_8BIT      = 16'h00FF;
  localparam logic [15:0] TOP_9BIT      = 16'h01FF;
  localparam logic [15:0] TOP_10BIT     = 16'h03FF;
  localparam logic [3:0]  WGM_FAST_TGL  = 4'hE;
  localparam logic [3:0]  WGM_DUAL_LO   = 4'h8;
  localparam logic [3:0]  WGM_DUAL_HI   = 4'hB;
  // ==========================================================
  // compare output mode values
  localparam logic [1:0]  COM_OFF       = 2'h0;
  localparam logic [1:0]  COM_TGL       = 2'h1;
  localparam logic [1:0]  COM_CLR       = 2'h2;
  localparam logic [1:0]  COM_SET       = 2'h3;
  // ==========================================================
  // encodings
  typedef enum logic [5:0] {CLS_NORMAL = 6'h01, CLS_CTC = 6'h02, CLS_FAST = 6'h04,
                            CLS_PC = 6'h08, CLS_PFC = 6'h10, CLS_RSVD = 6'h20} tcm_cls_t;
  typedef enum logic [5:0] {TOP_FFFF = 6'h01, TOP_00FF = 6'h02, TOP_01FF = 6'h04,
                            TOP_03FF = 6'h08, TOP_CAP = 6'h10, TOP_CMPA = 6'h20} tcm_top_t;
  typedef enum logic [2:0] {UPD_IMM = 3'h1, UPD_TOP = 3'h2, UPD_BOT = 3'h4} tcm_upd_t;
  typedef enum logic [1:0] {DIR_UP = 2'h1, DIR_DOWN = 2'h2} tcm_dir_t;
endpackage : tcm_pkg

/* File: tcm_mode_dec.sv */
// tcm_mode_dec: waveform number to mode class, TOP source and compare update point
module tcm_mode_dec
  import tcm_pkg::*;
(
  input  wire logic [3:0] wgm,
  output tcm_cls_t        cls,
  output tcm_top_t        top_sel,
  output tcm_upd_t        upd
);
  // ==========================================================
  // decode
  always_comb begin
    case (wgm)
      4'h0:                         cls = CLS_NORMAL;
      4'h1, 4'h2, 4'h3, 4'hA, 4'hB: cls = CLS_PC;
      4'h4, 4'hC:                   cls = CLS_CTC;
      4'h5, 4'h6, 4'h7, 4'hE, 4'hF: cls = CLS_FAST;
      4'h8, 4'h9:                   cls = CLS_PFC;
      default:                      cls = CLS_RSVD;
    endcase
    case (wgm)
      4'h1, 4'h5:                   top_sel = TOP_00FF;
      4'h2, 4'h6:                   top_sel = TOP_01FF;
      4'h3, 4'h7:                   top_sel = TOP_03FF;
      4'h8, 4'hA, 4'hC, 4'hE:       top_sel = TOP_CAP;
      4'h4, 4'h9, 4'hB, 4'hF:       top_sel = TOP_CMPA;
      default:                      top_sel = TOP_FFFF;
    endcase
    case (cls)
      CLS_FAST, CLS_PC:             upd = UPD_TOP;
      CLS_PFC:                      upd = UPD_BOT;
      default:                      upd = UPD_IMM;
    endcase
  end
endmodule : tcm_mode_dec

/* File: tcm_out_chan.sv */
// tcm_out_chan: one compare output channel, action on match and at TOP
module tcm_out_chan
  import tcm_pkg::*;
#(
  parameter bit IS_CHAN_A = 1'b0
)
(
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       tick,
  input  wire logic [3:0] wgm,
  input  wire tcm_cls_t   cls,
  input  wire logic [1:0] com,
  input  wire logic       match,
  input  wire logic       at_top,
  input  wire logic       cnt_up,
  output logic            oc_r,
  output logic            linked
);
  logic pwm_fast;
  logic pwm_dual;
  logic tgl_ok;
  logic oc_nxt;

  assign pwm_fast = (cls == CLS_FAST);
  assign pwm_dual = (cls == CLS_PC) || (cls == CLS_PFC);
  // toggle is free in non-PWM; in PWM only channel A in the listed waveforms
  assign tgl_ok   = !(pwm_fast || pwm_dual) ||
                    (IS_CHAN_A && (pwm_fast ? (wgm >= WGM_FAST_TGL) :
                                   ((wgm >= WGM_DUAL_LO) && (wgm <= WGM_DUAL_HI))));
  assign linked   = (com != COM_OFF) && ((com != COM_TGL) || tgl_ok);

  // ==========================================================
  // output action
  always_comb begin
    oc_nxt = oc_r;
    if (cls != CLS_RSVD) begin
      if (com == COM_TGL) begin
        if (tgl_ok && match) begin
          oc_nxt = !oc_r;
        end
      end else if (com != COM_OFF) begin
        if (pwm_fast) begin
          if (at_top) begin
            oc_nxt = (com == COM_CLR);
          end else if (match) begin
            oc_nxt = (com == COM_SET);
          end
        end else if (pwm_dual) begin
          if (match) begin
            oc_nxt = ((com == COM_SET) == cnt_up);
          end
        end else if (match) begin
          oc_nxt = (com == COM_SET);
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      oc_r <= 1'b0;
    end else if (tick) begin
      oc_r <= oc_nxt;
    end
  end
endmodule : tcm_out_chan

/* File: tcm_pad_model.sv */
// tcm_pad_model: port pad with a pull-up, driven only while its enable is high
module tcm_pad_model #(
  parameter bit PULL = 1'b1
)(
  input  wire logic pin,
  input  wire logic oe,
  output logic      pad
);
  // ==========================================================
  // pad level
  // released pad floats to the pull level, never the last value
  assign pad = oe ? pin : PULL;
endmodule : tcm_pad_model

/* File: timer_compare_output_mode_control_tb.sv */
// timer_compare_output_mode_control_tb: self-checking bench of the compare-output timer stage
module timer_compare_output_mode_control_tb
  import tcm_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // signals
  logic        ref_clk;
  logic        rst_n;
  logic        clk_en;
  logic        tick;
  logic [4:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [2:0]  pdat;
  logic [2:0]  pdir;
  logic [2:0]  pin;
  logic [2:0]  pin_oe;
  logic [2:0]  pad;
  logic [2:0]  lk;
  logic [3:0]  w;
  logic [5:0]  f;
  logic [31:0] q;
  int          failures;
  int          samples_checked;
  localparam logic [3:0] CW [6] = '{4'h0, 4'hE, 4'hF, 4'h5, 4'h9, 4'h3};
  // ==========================================================
  // design and pads
  tcm_top uut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .timer_tick_enable(tick),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .port_data_a(pdat[0]), .port_data_b(pdat[1]),
    .port_data_c(pdat[2]), .port_dir_a(pdir[0]), .port_dir_b(pdir[1]), .port_dir_c(pdir[2]),
    .chan_a_compare_pin(pin[0]), .chan_b_compare_pin(pin[1]), .chan_c_compare_pin(pin[2]),
    .chan_a_compare_pin_oe(pin_oe[0]), .chan_b_compare_pin_oe(pin_oe[1]),
    .chan_c_compare_pin_oe(pin_oe[2]));
  tcm_pad_model u_pad_a (.pin(pin[0]), .oe(pin_oe[0]), .pad(pad[0]));
  tcm_pad_model u_pad_b (.pin(pin[1]), .oe(pin_oe[1]), .pad(pad[1]));
  tcm_pad_model u_pad_c (.pin(pin[2]), .oe(pin_oe[2]), .pad(pad[2]));
  always #5 ref_clk = ~ref_clk;
  // ==========================================================
  // tasks and expectations
  task automatic results();
    $display("failures=%0d samples_checked=%0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic we, input logic [4:0] a, input logic [31:0] d);
    int   n;
    logic ws;
    n = 0;
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= 4'hF;
    avs_write      <= we;
    avs_read       <= ~we;
    // look at settled slave outputs mid-cycle: they are what the next rising edge samples
    do begin
      @(negedge ref_clk);
      ws = avs_waitrequest;
      q  = avs_readdata;
      n++;
      if (n > 20) begin
        failures++;
        $display("[ERR] %0t bus timeout", $time);
        results();
      end
      @(posedge ref_clk);
    end while (ws !== 1'b0);
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge ref_clk);
  endtask : bus
  task automatic rd(input logic [4:0] a);
    bus(1'b0, a, 32'h0000_0000);
  endtask : rd
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic set_wave(input logic [3:0] wv, input logic [5:0] fl);
    wr(OFS_CTRL_B, {27'h0, wv[3:2], 3'h0});
    wr(OFS_CTRL_A, {24'h0, fl, wv[1:0]});
  endtask : set_wave
  task automatic ticks(input int n);
    tick <= 1'b1;
    repeat (n) @(posedge ref_clk);
    tick <= 1'b0;
    @(posedge ref_clk);
  endtask : ticks
  task automatic pins(input logic [2:0] l, input logic [2:0] oc);
    logic e;
    for (int i = 0; i < 3; i++) begin
      e = l[i] ? oc[i] : pdat[i];
      chk(32'(pin[i]), 32'(e));
      chk(32'(pin_oe[i]), 32'(pdir[i]));
      chk(32'(pad[i]), 32'(pdir[i] ? e : 1'b1));
    end
  endtask : pins
  // pin taken over by the compare output for this waveform and field
  function automatic logic exp_link(input logic [3:0] wv, input int ch, input logic [1:0] c);
    if (c == COM_OFF) return 1'b0;
    if (c != COM_TGL) return 1'b1;
    if (wv inside {4'h0, 4'h4, 4'hC}) return 1'b1;
    if (ch != 0) return 1'b0;
    if (wv inside {4'h5, 4'h6, 4'h7, 4'hE, 4'hF}) return wv >= WGM_FAST_TGL;
    return wv >= WGM_DUAL_LO && wv <= WGM_DUAL_HI;
  endfunction : exp_link
  // ==========================================================
  // main sequence
  initial begin
    {ref_clk, rst_n, tick, avs_read, avs_write} = '0;
    {avs_address, avs_writedata, avs_byteenable, pdat, pdir} = '0;
    clk_en = 1'b1;
    failures = 0;
    samples_checked = 0;
    void'($urandom(71952));
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    rd(OFS_CTRL_A);
    chk(q, 32'h0);
    rd(OFS_STATUS);
    chk(q, 32'h0);
    wr(OFS_CTRL_B, 32'hFFFF_FFFF);
    rd(OFS_CTRL_B);
    chk(q, 32'h18);
    for (int k = 0; k < 30; k++) begin
      w = (k < 6) ? CW[k] : 4'($urandom_range(15, 0));
      if (w == 4'hD) w = 4'hC;
      f = (k < 6) ? 6'h15 : 6'($urandom);
      pdat <= 3'($urandom);
      pdir <= 3'($urandom);
      set_wave(w, f);
      rd(OFS_CTRL_A);
      chk(q, {24'h0, f, w[1:0]});
      rd(OFS_CTRL_B);
      chk(q, {27'h0, w[3:2], 3'h0});
      for (int i = 0; i < 3; i++) lk[i] = exp_link(w, i, f[5-2*i -: 2]);
      rd(OFS_STATUS);
      chk(32'(q[5:3]), 32'(lk));
      pins(lk, q[2:0]);
    end
    // non-PWM set, clear, toggle on match
    pdat <= 3'b000;
    pdir <= 3'b111;
    set_wave(4'h0, 6'h00);
    wr(OFS_CMP_A, 32'h40);
    wr(OFS_CMP_B, 32'h40);
    wr(OFS_CMP_C, 32'h60);
    wr(OFS_COUNT, 32'h40);
    set_wave(4'h0, 6'h3F);
    wr(OFS_CMP_C, 32'h40);
    wr(OFS_COUNT, 32'h40);
    ticks(1);
    rd(OFS_STATUS);
    chk(32'(q[2:0]), 32'h7);
    wr(OFS_COUNT, 32'h40);
    set_wave(4'h0, 6'h1A);
    ticks(1);
    rd(OFS_STATUS);
    chk(32'(q[2:0]), 32'h0);
    wr(OFS_COUNT, 32'h40);
    set_wave(4'h0, 6'h15);
    ticks(4);
    rd(OFS_STATUS);
    chk(32'(q[2:0]), 32'h7);
    pins(3'b111, 3'b111);
    wr(OFS_COUNT, 32'h40);
    clk_en <= 1'b0;
    tick <= 1'b1;
    repeat (3) @(posedge ref_clk);
    clk_en <= 1'b1;
    tick <= 1'b0;
    @(posedge ref_clk);
    rd(OFS_STATUS);
    chk(32'(q[2:0]), 32'h7);
    // fast PWM, TOP from capture register
    wr(OFS_CAP_TOP, 32'h60);
    set_wave(4'hE, 6'h2F);
    wr(OFS_COUNT, 32'h40);
    ticks(1);
    rd(OFS_STATUS);
    chk(32'(q[2:0]), 32'h6);
    wr(OFS_CMP_C, 32'h60);
    wr(OFS_COUNT, 32'h60);
    ticks(1);
    rd(OFS_STATUS);
    chk(32'(q[2:0]), 32'h1);
    set_wave(4'hE, 6'h2E);
    wr(OFS_COUNT, 32'h60);
    ticks(1);
    rd(OFS_STATUS);
    chk(32'(q[2:0]), 32'h5);
    // dual slope, up match then down match
    set_wave(4'hA, 6'h2C);
    wr(OFS_COUNT, 32'h40);
    ticks(1);
    rd(OFS_STATUS);
    chk(32'(q[1:0]), 32'h2);
    ticks(63);
    rd(OFS_STATUS);
    chk(32'({q[6], q[1:0]}), 32'h6);
    ticks(1);
    rd(OFS_STATUS);
    chk(32'(q[1:0]), 32'h1);
    // TOP from channel A compare, toggle once per TOP
    set_wave(4'hB, 6'h10);
    wr(OFS_COUNT, 32'h40);
    ticks(1);
    rd(OFS_STATUS);
    chk(32'(q[0]), 32'h0);
    ticks(127);
    rd(OFS_STATUS);
    chk(32'(q[0]), 32'h0);
    ticks(1);
    rd(OFS_STATUS);
    chk(32'(q[0]), 32'h1);
    // phase and frequency correct: compare loads at BOTTOM only
    set_wave(4'h8, 6'h0C);
    wr(OFS_CMP_B, 32'h50);
    wr(OFS_COUNT, 32'h0);
    ticks(81);
    rd(OFS_STATUS);
    chk(32'(q[1]), 32'h1);
    wr(OFS_CMP_B, 32'h30);
    ticks(32);
    rd(OFS_STATUS);
    chk(32'({q[6], q[1]}), 32'h2);
    results();
  end
endmodule : timer_compare_output_mode_control_tb
